// ===== core/lvr_pkg.sv
// Package of offsets, field positions, codes and counts for the low-voltage reset control
package lvr_pkg;

  // Register offsets
  localparam logic [7:0] PROGRAM_FLAG_STATUS_OFF = 8'h86;
  localparam logic [7:0] EVENT_STATUS_OFF        = 8'h90;
  localparam logic [7:0] EVENT_MASK_OFF          = 8'h91;

  // Field positions in program_flag_status
  localparam int CAUSE_MSB     = 7;
  localparam int CAUSE_LSB     = 6;
  localparam int UPPER_FLAG_BIT = 5;
  localparam int LOWER_FLAG_BIT = 4;
  localparam int ALU_MSB        = 2;

  // Reset cause codes (timeout bit, power-down bit)
  localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
  localparam logic [1:0] CAUSE_POWER    = 2'h2;
  localparam logic [1:0] CAUSE_EXTERNAL = 2'h3;

  // Detector build options
  typedef enum logic [1:0] {
    detector_option_lowest  = 2'h0,
    detector_option_medium  = 2'h1,
    detector_option_high    = 2'h2,
    detector_option_maximum = 2'h3
  } detector_option_e;

  // Event bits of the event status register
  localparam int EVT_W         = 4;
  localparam int EVT_LVD_RESET = 0;
  localparam int EVT_WDT_RESET = 1;
  localparam int EVT_EXT_RESET = 2;
  localparam int EVT_LOW_SUPPLY = 3;

  // Reset values
  localparam logic [2:0]       ALU_RST  = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 4'h0;

  // Sense inputs: {pin_n, below_36, below_24, below_20}
  localparam int         SENSE_W   = 4;
  localparam logic [3:0] SENSE_RST = 4'h7;  // Pin low, supply low: safest guess

  // Oscillator warm-up length in system clocks
  localparam int WARM_CYCLES = 64;

endpackage : lvr_pkg

// ===== core/sense_if.sv
// Interface carrying raw and synchronised sense inputs
`timescale 1ns/1ps
`default_nettype none
interface sense_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport ctrl (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : sense_if
`default_nettype wire

// ===== core/sense_sync.sv
// Two-flop synchroniser for the pin and comparator inputs
`timescale 1ns/1ps
`default_nettype none
module sense_sync
  import lvr_pkg::*;
#(
  parameter int              W       = SENSE_W,
  parameter logic [W-1:0]    RST_VAL = SENSE_RST
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Sense bundle
  sense_if.sync     sense
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= sense.raw;
      sync_ff <= meta_ff;
    end
  end

  assign sense.synced = sync_ff;

endmodule : sense_sync
`default_nettype wire

// ===== core/low_voltage_reset_control.sv
// Reset sequencer with low-voltage detector options, flags and cause register
// Functional notes
// - Lowest threshold resets under every option
// - Lowest option: reset below 2.0V, no flags
// - Medium option: 2.0V reset, lower flag only
// - High option: 2.4V reset, upper flag only
// - Maximum option: 3.6V reset, no flags
// - Flags cleared after detector reset
// - Flags read-only bits 5 and 4
// - Enabled reset pin is active low
// - Pin honoured at power-up and running
// - Wait pin, initialise, warm up, start zero
// - Watchdog overflow starts full reset sequence
// - Stay in reset while supply too low
// - Cause code in bits 7 and 6
// - Pin as plain input when option off
`timescale 1ns/1ps
`default_nettype none
module low_voltage_reset_control
  import lvr_pkg::*;
#(
  parameter int WARM_CYCLES_P = WARM_CYCLES
) (
  // Clock and power-on reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Build options
  input  wire logic [1:0] detector_option_i,
  input  wire logic       ext_reset_enable_i,
  // Pin and analog comparator outputs, asynchronous
  input  wire logic       reset_pin_n_i,
  input  wire logic       below_20_i,
  input  wire logic       below_24_i,
  input  wire logic       below_36_i,
  // Watchdog overflow, one-cycle pulse
  input  wire logic       wdt_overflow_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // System side
  output logic            sys_reset_o,
  output logic            exec_start_o,
  output logic            port_in_o,
  output logic            low_supply_lower_flag_o,
  output logic            low_supply_upper_flag_o,
  output logic            irq_o
);

  localparam int WARM_W = $clog2(WARM_CYCLES_P + 1);
  localparam logic [WARM_W-1:0] WARM_LAST = WARM_W'(WARM_CYCLES_P - 1);

  // Elaboration check on the warm-up count
  if (WARM_CYCLES_P < 1) begin : g_bad_warm
    $error("WARM_CYCLES_P must be at least 1");
  end

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_INIT = 4'h2,
    ST_WARM = 4'h4,
    ST_RUN  = 4'h8
  } seq_state_e;

  typedef struct packed {
    seq_state_e        state;
    logic [1:0]        cause;
    logic [2:0]        alu;
    logic              flag_lo;
    logic              flag_hi;
    logic [WARM_W-1:0] warm;
    logic [EVT_W-1:0]  evt;
    logic [EVT_W-1:0]  mask;
    logic [7:0]        rdata;
    logic              start;
  } lvr_state_s;

  lvr_state_s state_ff;
  lvr_state_s nxt_state;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  sense_if #(.W(SENSE_W)) sense ();
  assign sense.raw = {reset_pin_n_i, below_36_i, below_24_i, below_20_i};

  sense_sync #(
    .W       (SENSE_W),
    .RST_VAL (SENSE_RST)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .sense      (sense)
  );

  logic pin_n_s;
  logic b20_s;
  logic b24_s;
  logic b36_s;
  assign {pin_n_s, b36_s, b24_s, b20_s} = sense.synced;

  ////////////////////////////////////////////////////////////////////////////
  // Reset causes
  logic lvd_now;
  logic ext_now;
  logic opt_med;
  logic opt_high;
  logic opt_max;
  assign opt_med  = detector_option_i == detector_option_medium;
  assign opt_high = detector_option_i == detector_option_high;
  assign opt_max  = detector_option_i == detector_option_maximum;

  // 2.0V level is always armed; higher levels added by option
  assign lvd_now = b20_s
                 | ((opt_high | opt_max) & b24_s)
                 | (opt_max & b36_s);
  assign ext_now = ext_reset_enable_i & ~pin_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic flo;
    logic fhi;
    logic [EVT_W-1:0] set_evt;
    flo       = 1'b0;
    fhi       = 1'b0;
    set_evt   = '0;
    nxt_state = state_ff;
    nxt_state.start = 1'b0;
    nxt_state.rdata = 8'h00;

    unique case (state_ff.state)
      ST_HOLD: begin
        // Leave only once supply and pin are both good
        if (!lvd_now && !ext_now) begin
          nxt_state.state = ST_INIT;
        end
      end
      ST_INIT: begin
        nxt_state.alu   = ALU_RST;
        nxt_state.warm  = '0;
        nxt_state.state = ST_WARM;
      end
      ST_WARM: begin
        nxt_state.warm = state_ff.warm + WARM_W'(1);
        if (state_ff.warm == WARM_LAST) begin
          nxt_state.state = ST_RUN;
          nxt_state.start = 1'b1;
        end
      end
      ST_RUN: begin
        // Supply beats pin beats watchdog when they coincide
        if (lvd_now) begin
          nxt_state.state = ST_HOLD;
          nxt_state.cause = CAUSE_POWER;
          set_evt[EVT_LVD_RESET] = 1'b1;
        end else if (ext_now) begin
          nxt_state.state = ST_HOLD;
          nxt_state.cause = CAUSE_EXTERNAL;
          set_evt[EVT_EXT_RESET] = 1'b1;
        end else if (wdt_overflow_i) begin
          nxt_state.state = ST_HOLD;
          nxt_state.cause = CAUSE_WATCHDOG;
          set_evt[EVT_WDT_RESET] = 1'b1;
        end else begin
          flo = (opt_med | opt_high) & b24_s;
          fhi = opt_high & b36_s;
        end
      end
    endcase

    // Flags live only while running, so any reset clears them
    nxt_state.flag_lo = flo;
    nxt_state.flag_hi = fhi;
    set_evt[EVT_LOW_SUPPLY] = flo & ~state_ff.flag_lo;

    // Software writes; flag bits are not writable
    if (reg_wr_i && state_ff.state == ST_RUN) begin
      if (hit(reg_addr_i, PROGRAM_FLAG_STATUS_OFF)) begin
        nxt_state.cause = reg_wdata_i[CAUSE_MSB:CAUSE_LSB];
        nxt_state.alu   = reg_wdata_i[ALU_MSB:0];
      end
      if (hit(reg_addr_i, EVENT_MASK_OFF)) begin
        nxt_state.mask = reg_wdata_i[EVT_W-1:0];
      end
    end

    // Reads answer next cycle; event status read clears, new events win
    if (reg_rd_i) begin
      if (hit(reg_addr_i, PROGRAM_FLAG_STATUS_OFF)) begin
        nxt_state.rdata = {state_ff.cause, state_ff.flag_hi, state_ff.flag_lo,
                           1'b0, state_ff.alu};
      end else if (hit(reg_addr_i, EVENT_STATUS_OFF)) begin
        nxt_state.rdata = {{(8-EVT_W){1'b0}}, state_ff.evt};
        nxt_state.evt   = '0;
      end else if (hit(reg_addr_i, EVENT_MASK_OFF)) begin
        nxt_state.rdata = {{(8-EVT_W){1'b0}}, state_ff.mask};
      end
    end
    nxt_state.evt = nxt_state.evt | set_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; power-on reset records the power cause
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '{state: ST_HOLD, cause: CAUSE_POWER, alu: ALU_RST, flag_lo: 1'b0,
                    flag_hi: 1'b0, warm: '0, evt: '0, mask: MASK_RST, rdata: 8'h00,
                    start: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; system reset rises straight from the power-on input
  assign sys_reset_o             = rst_i | (state_ff.state != ST_RUN);
  assign exec_start_o            = state_ff.start;
  assign port_in_o               = ~ext_reset_enable_i & pin_n_s;
  assign low_supply_lower_flag_o = state_ff.flag_lo;
  assign low_supply_upper_flag_o = state_ff.flag_hi;
  assign reg_rdata_o             = state_ff.rdata;
  assign irq_o                   = |(state_ff.evt & state_ff.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_lowest_resets;
    (state_ff.state == ST_RUN) && b20_s |=> sys_reset_o && state_ff.cause == CAUSE_POWER;
  endproperty
  a_lowest_resets: assert property (p_lowest_resets)
    else $error("2.0V level did not reset");

  property p_lowest_no_flags;
    detector_option_i == detector_option_lowest |=> !state_ff.flag_lo && !state_ff.flag_hi;
  endproperty
  a_lowest_no_flags: assert property (p_lowest_no_flags)
    else $error("flag set under lowest option");

  property p_medium_flags;
    (state_ff.state == ST_RUN) && opt_med && !lvd_now && !ext_now && !wdt_overflow_i
      |=> state_ff.flag_lo == $past(b24_s) && !state_ff.flag_hi;
  endproperty
  a_medium_flags: assert property (p_medium_flags)
    else $error("medium option flags wrong");

  property p_high_reset_24;
    (state_ff.state == ST_RUN) && opt_high && b24_s |=> state_ff.state == ST_HOLD;
  endproperty
  a_high_reset_24: assert property (p_high_reset_24)
    else $error("high option missed 2.4V reset");

  property p_max_no_flags;
    opt_max |=> !low_supply_lower_flag_o && !low_supply_upper_flag_o;
  endproperty
  a_max_no_flags: assert property (p_max_no_flags)
    else $error("flag set under maximum option");

  property p_flags_clear;
    state_ff.state != ST_RUN |-> !state_ff.flag_lo && !state_ff.flag_hi;
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("flag survived reset");

  property p_flag_read;
    reg_rd_i && hit(reg_addr_i, PROGRAM_FLAG_STATUS_OFF)
      |=> reg_rdata_o[5:4] == {$past(state_ff.flag_hi), $past(state_ff.flag_lo)};
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag bits read wrong");

  property p_pin_holds;
    ext_reset_enable_i && !pin_n_s ##1 ext_reset_enable_i && !pin_n_s |-> sys_reset_o;
  endproperty
  a_pin_holds: assert property (p_pin_holds)
    else $error("low pin did not hold reset");

  property p_init_after_pin;
    state_ff.state == ST_INIT |-> $past(!lvd_now && !ext_now);
  endproperty
  a_init_after_pin: assert property (p_init_after_pin)
    else $error("init began while pin or supply low");

  property p_wdt_reset;
    (state_ff.state == ST_RUN) && wdt_overflow_i && !lvd_now && !ext_now
      |=> sys_reset_o && state_ff.cause == CAUSE_WATCHDOG;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("watchdog overflow ignored");

  property p_stay_low;
    (state_ff.state == ST_HOLD) && lvd_now |=> state_ff.state == ST_HOLD;
  endproperty
  a_stay_low: assert property (p_stay_low)
    else $error("left reset with low supply");

  property p_ext_cause;
    (state_ff.state == ST_RUN) && ext_now && !lvd_now |=> state_ff.cause == CAUSE_EXTERNAL;
  endproperty
  a_ext_cause: assert property (p_ext_cause)
    else $error("external cause not recorded");

  property p_pin_gpio;
    !ext_reset_enable_i && (state_ff.state == ST_RUN) && !lvd_now && !wdt_overflow_i
      |=> state_ff.state == ST_RUN;
  endproperty
  a_pin_gpio: assert property (p_pin_gpio)
    else $error("disabled pin caused reset");

  property p_start_after_warm;
    exec_start_o |-> $past(state_ff.state == ST_WARM) && state_ff.state == ST_RUN;
  endproperty
  a_start_after_warm: assert property (p_start_after_warm)
    else $error("start pulse out of place");

endmodule : low_voltage_reset_control
`default_nettype wire

// ===== bench/ext_reset_source.sv
// Model of the outside reset circuit that drives the reset pin
`timescale 1ns/1ps
`default_nettype none
module ext_reset_source #(
  parameter int SLOW = 5
) (
  // Clock
  input  wire logic core_clk_i,
  // Bench commands
  input  wire logic press_i,
  input  wire logic slow_i,
  // Pin
  output logic      reset_pin_n_o
);
  int cnt;
  // Pin idles high like a pulled-up line; slow mode mimics an RC release
  initial reset_pin_n_o = 1'b1;
  always @(posedge core_clk_i) begin
    if (press_i) begin
      reset_pin_n_o <= 1'b0;
      cnt <= SLOW;
    end else if (slow_i && cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      reset_pin_n_o <= 1'b1;
    end
  end
endmodule // ext_reset_source
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the low-voltage reset control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lvr_pkg::*;
  logic       core_clk_i, rst_i, ext_en, press, slow, pin_n, b20, b24, b36, wdt;
  logic [1:0] det_opt;
  logic [7:0] addr, wdata, rdata, rv, r;
  logic       wr, rd, sys_rst, exec_start, port_in, flag_lo, flag_hi, irq;
  logic [1:0] fe;
  int         fails, tests_run;

  ext_reset_source ext_reset_source_i (.core_clk_i(core_clk_i), .press_i(press),
    .slow_i(slow), .reset_pin_n_o(pin_n));
  // Short warm-up keeps every reset sequence brief
  low_voltage_reset_control #(.WARM_CYCLES_P(4)) low_voltage_reset_control_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .detector_option_i(det_opt),
    .ext_reset_enable_i(ext_en), .reset_pin_n_i(pin_n), .below_20_i(b20),
    .below_24_i(b24), .below_36_i(b36), .wdt_overflow_i(wdt), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .sys_reset_o(sys_rst), .exec_start_o(exec_start), .port_in_o(port_in),
    .low_supply_lower_flag_o(flag_lo), .low_supply_upper_flag_o(flag_hi), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected flag pair {upper, lower} for an option and comparator levels
  function automatic logic [1:0] flags_exp(input logic [1:0] o, input logic l24,
                                           input logic l36);
    return {(o == detector_option_high) & l36,
            ((o == detector_option_medium) | (o == detector_option_high)) & l24};
  endfunction

  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_rst(input int n);
    for (int i = 0; i < n && sys_rst !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    check_bit(sys_rst, 1'b1, "reset entered");
  endtask

  task automatic wait_run();
    for (int i = 0; i < 100 && exec_start !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    check_bit(exec_start, 1'b1, "start pulse");
    check_bit(sys_rst, 1'b0, "reset released");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the limit is far above the several hundred cycles needed
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1; det_opt = detector_option_lowest; ext_en = 1'b1; press = 1'b1;
    slow = 1'b1; b20 = 1'b0; b24 = 1'b0; b36 = 1'b0; wdt = 1'b0; addr = 8'h00;
    wdata = 8'h00; wr = 1'b0; rd = 1'b0; fails = 0; tests_run = 0;
    void'($urandom(32'hf094fccb));
    cyc(12);
    rst_i <= 1'b0;
    cyc(10);
    #1 check_bit(sys_rst, 1'b1, "pin low at power-up");
    cyc(1);
    press <= 1'b0;
    wait_run();
    rd_reg(PROGRAM_FLAG_STATUS_OFF, rv);
    check_byte(rv, 8'h80, "flag register after power-up");
    rd_reg(8'h55, rv);
    check_byte(rv, 8'h00, "unmapped read");
    // Flag levels per option, supply kept above every reset level
    for (int o = 0; o < 4; o++) begin
      for (int k = 0; k < 6; k++) begin
        r = 8'($urandom);
        cyc(1);
        b24 <= r[0] & (o < 2);
        b36 <= r[1] & (o != 3);
        det_opt <= 2'(o);
        cyc(5);
        #1 fe = flags_exp(2'(o), b24, b36);
        check_bit(flag_lo, fe[0], "lower flag");
        check_bit(flag_hi, fe[1], "upper flag");
        check_bit(sys_rst, 1'b0, "no reset above level");
        rd_reg(PROGRAM_FLAG_STATUS_OFF, rv);
        check_byte({6'h0, rv[5:4]}, {6'h0, fe}, "flag bits");
      end
      cyc(1);
      b24 <= 1'b0;
      b36 <= 1'b0;
      cyc(4);
    end
    // Detector resets for every option and level that should reset
    for (int o = 0; o < 4; o++) begin
      for (int l = 0; l < 3; l++) begin
        if (l == 0 || (l == 1 && o >= 2) || (l == 2 && o == 3)) begin
          cyc(1);
          det_opt <= 2'(o);
          r = 8'($urandom);
          wr_reg(PROGRAM_FLAG_STATUS_OFF, {5'h0, r[2:0]});
          b20 <= (l == 0);
          b24 <= (l == 1);
          b36 <= (l == 2);
          wait_rst(6);
          cyc(20);
          #1 check_bit(sys_rst, 1'b1, "held while supply low");
          check_bit(flag_lo | flag_hi, 1'b0, "flags in reset");
          cyc(1);
          b20 <= 1'b0;
          b24 <= 1'b0;
          b36 <= 1'b0;
          wait_run();
          rd_reg(PROGRAM_FLAG_STATUS_OFF, rv);
          check_byte(rv, 8'h80, "cause after detector reset");
        end
      end
    end
    // Pin reset while running, slow release
    cyc(1);
    press <= 1'b1;
    wait_rst(6);
    cyc(10);
    press <= 1'b0;
    wait_run();
    rd_reg(PROGRAM_FLAG_STATUS_OFF, rv);
    check_byte(rv, 8'hc0, "cause after pin reset");
    // Pin as a plain input
    cyc(1);
    ext_en <= 1'b0;
    press <= 1'b1;
    cyc(6);
    #1 check_bit(sys_rst, 1'b0, "pin ignored");
    check_bit(port_in, 1'b0, "port low");
    cyc(1);
    press <= 1'b0;
    slow <= 1'b0;
    cyc(6);
    #1 check_bit(port_in, 1'b1, "port high");
    cyc(1);
    ext_en <= 1'b1;
    // Read-only flag bits, then watchdog reset
    wr_reg(PROGRAM_FLAG_STATUS_OFF, 8'h7d);
    rd_reg(PROGRAM_FLAG_STATUS_OFF, rv);
    check_byte(rv, 8'h45, "write mask of flag register");
    cyc(1);
    wdt <= 1'b1;
    cyc(1);
    wdt <= 1'b0;
    wait_rst(3);
    wait_run();
    rd_reg(PROGRAM_FLAG_STATUS_OFF, rv);
    check_byte(rv, 8'h00, "cause after watchdog");
    // Interrupt: masked event, unmask, read-clear
    rd_reg(EVENT_STATUS_OFF, rv);
    wr_reg(EVENT_MASK_OFF, 8'h00);
    det_opt <= detector_option_medium;
    cyc(4);
    b24 <= 1'b1;
    cyc(6);
    #1 check_bit(irq, 1'b0, "masked event");
    check_bit(flag_lo, 1'b1, "lower flag set");
    wr_reg(EVENT_MASK_OFF, 8'h08);
    cyc(2);
    #1 check_bit(irq, 1'b1, "unmasked event");
    rd_reg(EVENT_STATUS_OFF, rv);
    check_byte(rv, 8'h08, "event status");
    cyc(2);
    #1 check_bit(irq, 1'b0, "cleared by read");
    cyc(1);
    b24 <= 1'b0;
    cyc(4);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
